// ===== hw/phd_ctrl.v
// peak-and-hold solenoid current controller with register port
`timescale 1ns/1ns
`include "phd_defines.vh"

// Behaviour
// - enable rising starts an activation
// - peak phase for dwell, then hold
// - hold continues while enable high
// - enable low stops gate switching
// - gate high while current below reference
// - comparator trip drops gate until tick
// - gate high at least minimum duty
// - independent settings, hold is one sixth
// - low setting clamps to default reference
// - dwell end switches reference to hold
// - each on cycle starts at pwm_tick
// - fault output released on uvlo or thermal
module phd_ctrl #(
   parameter KEEP_W   = 24,
   parameter KEEP_DEF = `PHD_KEEP_RST_US,
   parameter PER_W    = 16
)(
   // clock and reset
   input  wire                  core_clk_in,
   input  wire                  rst_n_in,
   // register port
   input  wire [7:0]            reg_addr_in,
   input  wire [31:0]           reg_wdata_in,
   input  wire                  reg_wr_in,
   input  wire                  reg_rd_in,
   output reg  [31:0]           reg_rdata_out,
   // controller and analog side
   input  wire                  enable_in,
   input  wire                  cmp_above_in,
   input  wire                  uvlo_in,
   input  wire                  tsd_in,
   // driver side
   output reg                   gate_out,
   output reg  [`PHD_REF_W-1:0] vref_code_out,
   output reg                   hold_sel_out,
   output reg                   status_out,
   output reg                   status_oe_n_out,
   // interrupt
   output reg                   irq_out
);

   // ------------------------------------------------------------
   // phase codes
   // ------------------------------------------------------------
   localparam [1:0] PH_IDLE = 2'b00;
   localparam [1:0] PH_PEAK = 2'b01;
   localparam [1:0] PH_HOLD = 2'b10;

   // dwell reset value at a fixed width for the part-select below
   localparam [31:0] KEEP_DEF32 = KEEP_DEF;

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   reg  [1:0]            phase_reg;     // activation phase
   reg  [1:0]            phase_next;
   reg  [KEEP_W-1:0]     dwell_reg;     // microseconds spent in peak
   reg  [KEEP_W-1:0]     dwell_next;
   reg                   en_prev_reg;   // enable of last cycle
   reg  [PER_W-1:0]      on_cnt_reg;    // cycles gate has been high
   reg  [PER_W-1:0]      on_cnt_next;
   reg                   gate_next;
   reg  [`PHD_REF_W-1:0] peak_set_reg;  // peak setting
   reg  [`PHD_REF_W-1:0] hold_set_reg;  // hold setting
   reg  [KEEP_W-1:0]     keep_reg;      // dwell time in microseconds
   reg  [PER_W-1:0]      period_reg;    // pwm period in cycles
   reg  [`PHD_EV_W-1:0]  irq_stat_reg;  // sticky events
   reg  [`PHD_EV_W-1:0]  irq_stat_next;
   reg  [`PHD_EV_W-1:0]  irq_mask_reg;  // event enables
   reg                   fault_prev_reg;
   reg  [31:0]           rdata_next;
   reg  [`PHD_EV_W-1:0]  ev;            // events of this cycle
   wire                  pwm_tick;      // start of each on cycle
   wire                  us_tick;       // one per microsecond
   wire [`PHD_REF_W-1:0] ref_sel;       // selected reference
   wire                  fault;         // uvlo or thermal shutdown
   wire                  en_rise;
   wire                  en_fall;
   wire [17:0]           min_prod;      // period times duty numerator, plus rounding
   wire [17:0]           min_quot;      // minimum on cycles, full width
   wire [PER_W-1:0]      min_on;        // minimum on cycles
   wire                  trip;          // comparator ends on time

   assign fault   = uvlo_in | tsd_in;
   assign en_rise = enable_in & ~en_prev_reg;
   assign en_fall = ~enable_in & en_prev_reg;

   // minimum on time from period
   // rounded up: a truncated count would fall short of the fraction
   assign min_prod = {{(18-PER_W){1'b0}}, period_reg} * `PHD_DMIN_NUM + `PHD_DMIN_RND;
   assign min_quot = min_prod / `PHD_DMIN_DEN;
   assign min_on   = min_quot[PER_W-1:0];
   assign trip     = gate_out & cmp_above_in & (on_cnt_reg >= min_on);

   // ------------------------------------------------------------
   // tick dividers
   // ------------------------------------------------------------
   // pwm clock from period register
   phd_div #(
      .W (PER_W)
   ) u_pwm_div (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .period_in   (period_reg),
      .tick_out    (pwm_tick)
   );

   phd_div #(
      .W (8)
   ) u_us_div (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .period_in   (`PHD_US_CYC),
      .tick_out    (us_tick)
   );

   // ------------------------------------------------------------
   // reference selection
   // ------------------------------------------------------------
   phd_ref u_ref (
      .peak_set_in (peak_set_reg),
      .hold_set_in (hold_set_reg),
      .hold_sel_in (phase_next == PH_HOLD),
      .ref_out     (ref_sel)
   );

   // ------------------------------------------------------------
   // phase and dwell timer
   // ------------------------------------------------------------
   always @*
   begin
      phase_next = phase_reg;
      dwell_next = dwell_reg;
      case (phase_reg)
         PH_IDLE:
         begin
            dwell_next = {KEEP_W{1'b0}};
            if (en_rise)
               phase_next = PH_PEAK;
         end
         PH_PEAK:
         begin
            if (!enable_in)
            begin
               phase_next = PH_IDLE;
               dwell_next = {KEEP_W{1'b0}};
            end
            else if (dwell_reg >= keep_reg)
               phase_next = PH_HOLD;
            else if (us_tick)
               dwell_next = dwell_reg + {{(KEEP_W-1){1'b0}}, 1'b1};
         end
         PH_HOLD:
         begin
            if (!enable_in)
            begin
               phase_next = PH_IDLE;
               dwell_next = {KEEP_W{1'b0}};
            end
         end
         default:
         begin
            phase_next = PH_IDLE;
            dwell_next = {KEEP_W{1'b0}};
         end
      endcase
   end

   // ------------------------------------------------------------
   // gate drive
   // ------------------------------------------------------------
   always @*
   begin
      gate_next   = gate_out;
      on_cnt_next = on_cnt_reg;
      if (phase_next == PH_IDLE || fault)
      begin
         gate_next   = 1'b0;
         on_cnt_next = {PER_W{1'b0}};
      end
      else if (pwm_tick)
      begin
         gate_next   = 1'b1;
         on_cnt_next = {{(PER_W-1){1'b0}}, 1'b1};
      end
      else if (trip)
         gate_next = 1'b0;
      else if (gate_out)
         on_cnt_next = on_cnt_reg + {{(PER_W-1){1'b0}}, 1'b1};
   end

   // ------------------------------------------------------------
   // events and sticky interrupt status
   // ------------------------------------------------------------
   always @*
   begin
      ev = {`PHD_EV_W{1'b0}};
      ev[`PHD_EV_START] = (phase_reg == PH_IDLE) & (phase_next == PH_PEAK);
      ev[`PHD_EV_HOLD]  = (phase_reg == PH_PEAK) & (phase_next == PH_HOLD);
      ev[`PHD_EV_ABORT] = en_fall & (phase_reg != PH_IDLE);
      ev[`PHD_EV_FAULT] = fault & ~fault_prev_reg;
      ev[`PHD_EV_TRIP]  = trip;
      irq_stat_next = irq_stat_reg;
      // write one clears
      if (reg_wr_in && reg_addr_in == `PHD_OFS_IRQ_STAT)
         irq_stat_next = irq_stat_reg & ~reg_wdata_in[`PHD_EV_W-1:0];
      // a new event wins over the clear
      irq_stat_next = irq_stat_next | ev;
   end

   // ------------------------------------------------------------
   // read data mux
   // ------------------------------------------------------------
   always @*
   begin
      rdata_next = 32'h00000000;
      case (reg_addr_in)
         `PHD_OFS_STATUS:
         begin
            rdata_next[`PHD_ST_PHASE_HI:`PHD_ST_PHASE_LO] = phase_reg;
            rdata_next[`PHD_ST_GATE]   = gate_out;
            rdata_next[`PHD_ST_FAULT]  = status_out;
            rdata_next[`PHD_ST_ENABLE] = en_prev_reg;
         end
         `PHD_OFS_PEAK_SET: rdata_next[`PHD_REF_W-1:0] = peak_set_reg;
         `PHD_OFS_HOLD_SET: rdata_next[`PHD_REF_W-1:0] = hold_set_reg;
         `PHD_OFS_KEEP:     rdata_next[KEEP_W-1:0]     = keep_reg;
         `PHD_OFS_PERIOD:   rdata_next[PER_W-1:0]      = period_reg;
         `PHD_OFS_IRQ_STAT: rdata_next[`PHD_EV_W-1:0]  = irq_stat_reg;
         `PHD_OFS_IRQ_MASK: rdata_next[`PHD_EV_W-1:0]  = irq_mask_reg;
         // unmapped reads as zero
         default:           rdata_next = 32'h00000000;
      endcase
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   // peak and hold set independently
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         peak_set_reg <= `PHD_PEAK_RST;
         hold_set_reg <= `PHD_HOLD_RST;
         keep_reg     <= KEEP_DEF32[KEEP_W-1:0];
         period_reg   <= `PHD_PERIOD_RST;
         irq_mask_reg <= `PHD_MASK_RST;
      end
      else if (reg_wr_in)
      begin
         case (reg_addr_in)
            `PHD_OFS_PEAK_SET: peak_set_reg <= reg_wdata_in[`PHD_REF_W-1:0];
            `PHD_OFS_HOLD_SET: hold_set_reg <= reg_wdata_in[`PHD_REF_W-1:0];
            `PHD_OFS_KEEP:     keep_reg     <= reg_wdata_in[KEEP_W-1:0];
            `PHD_OFS_PERIOD:   period_reg   <= reg_wdata_in[PER_W-1:0];
            `PHD_OFS_IRQ_MASK: irq_mask_reg <= reg_wdata_in[`PHD_EV_W-1:0];
            // read-only and unmapped writes ignored
            default:           period_reg   <= period_reg;
         endcase
      end
   end

   // ------------------------------------------------------------
   // state and output flops
   // ------------------------------------------------------------
   // reset to idle with gate low
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         phase_reg       <= PH_IDLE;
         dwell_reg       <= {KEEP_W{1'b0}};
         en_prev_reg     <= 1'b0;
         on_cnt_reg      <= {PER_W{1'b0}};
         gate_out        <= 1'b0;
         vref_code_out   <= `PHD_REF_DEFAULT;
         hold_sel_out    <= 1'b0;
         status_out      <= 1'b0;
         status_oe_n_out <= 1'b0;
         fault_prev_reg  <= 1'b0;
         irq_stat_reg    <= {`PHD_EV_W{1'b0}};
         irq_out         <= 1'b0;
         reg_rdata_out   <= 32'h00000000;
      end
      else
      begin
         phase_reg       <= phase_next;
         dwell_reg       <= dwell_next;
         en_prev_reg     <= enable_in;
         on_cnt_reg      <= on_cnt_next;
         gate_out        <= gate_next;
         vref_code_out   <= ref_sel;
         hold_sel_out    <= (phase_next == PH_HOLD);
         status_out      <= fault;
         status_oe_n_out <= fault;
         fault_prev_reg  <= fault;
         irq_stat_reg    <= irq_stat_next;
         irq_out         <= |(irq_stat_next & irq_mask_reg);
         reg_rdata_out   <= reg_rd_in ? rdata_next : 32'h00000000;
      end
   end

endmodule // phd_ctrl

// ===== hw/phd_defines.vh
// constants for the peak-and-hold solenoid pwm controller
`ifndef PHD_DEFINES_VH
`define PHD_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PHD_OFS_STATUS    8'h00
`define PHD_OFS_PEAK_SET  8'h04
`define PHD_OFS_HOLD_SET  8'h08
`define PHD_OFS_KEEP      8'h0c
`define PHD_OFS_PERIOD    8'h10
`define PHD_OFS_IRQ_STAT  8'h14
`define PHD_OFS_IRQ_MASK  8'h18

// ------------------------------------------------------------
// status register field positions
// ------------------------------------------------------------
`define PHD_ST_PHASE_LO   0
`define PHD_ST_PHASE_HI   1
`define PHD_ST_GATE       2
`define PHD_ST_FAULT      3
`define PHD_ST_ENABLE     4

// ------------------------------------------------------------
// event bits of irq status and mask
// ------------------------------------------------------------
`define PHD_EV_START      0
`define PHD_EV_HOLD       1
`define PHD_EV_ABORT      2
`define PHD_EV_FAULT      3
`define PHD_EV_TRIP       4
`define PHD_EV_W          5

// ------------------------------------------------------------
// reference levels and reset values
// ------------------------------------------------------------
`define PHD_REF_W         10
`define PHD_REF_DEFAULT   10'h12c
`define PHD_SET_MIN       10'h064
`define PHD_HOLD_DIV      10'h006
`define PHD_PEAK_RST      10'h000
`define PHD_HOLD_RST      10'h000
`define PHD_PERIOD_RST    16'h09c4
`define PHD_KEEP_RST_US   100000
`define PHD_MASK_RST      5'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PHD_CLK_NS        20
`define PHD_US_NS         1000
// one microsecond in core clock cycles, sized for the 8-bit divider
`define PHD_US_CYC        8'h32
`define PHD_DMIN_NUM      18'h00003
`define PHD_DMIN_DEN      18'h00028
// added before the divide so the minimum on time rounds up
`define PHD_DMIN_RND      18'h00027

`endif

// ===== hw/phd_div.v
// free-running divider giving a one-cycle tick every period_in cycles
`timescale 1ns/1ns
module phd_div #(
   parameter W = 16
)(
   // clock and reset
   input  wire         core_clk_in,
   input  wire         rst_n_in,
   // control
   input  wire [W-1:0] period_in,
   // tick
   output reg          tick_out
);

   reg [W-1:0] cnt_reg;   // cycles since last tick

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   // period 0 or 1 both tick every cycle
   always @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cnt_reg  <= {W{1'b0}};
         tick_out <= 1'b0;
      end
      else if (cnt_reg + {{(W-1){1'b0}}, 1'b1} >= period_in)
      begin
         cnt_reg  <= {W{1'b0}};
         tick_out <= 1'b1;
      end
      else
      begin
         cnt_reg  <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
         tick_out <= 1'b0;
      end
   end

endmodule // phd_div

// ===== hw/phd_ref.v
// reference level selection: clamp, peak or one sixth for hold
`timescale 1ns/1ns
`include "phd_defines.vh"
module phd_ref (
   // settings
   input  wire [`PHD_REF_W-1:0] peak_set_in,
   input  wire [`PHD_REF_W-1:0] hold_set_in,
   input  wire                  hold_sel_in,
   // selected reference
   output reg  [`PHD_REF_W-1:0] ref_out
);

   // ------------------------------------------------------------
   // selection
   // ------------------------------------------------------------
   // hold is one sixth
   always @*
   begin
      if (hold_sel_in)
      begin
         if (hold_set_in < `PHD_SET_MIN)
            ref_out = `PHD_REF_DEFAULT;
         else
            ref_out = hold_set_in / `PHD_HOLD_DIV;
      end
      else
      begin
         if (peak_set_in < `PHD_SET_MIN)
            ref_out = `PHD_REF_DEFAULT;
         else
            ref_out = peak_set_in;
      end
   end

endmodule // phd_ref

// ===== test/phd_coil_model.sv
// coil and power switch model giving the sense comparator level
`timescale 1ns/1ns
module phd_coil_model (
   // clock
   input  wire       core_clk_in,
   // switch side
   input  wire       gate_in,
   input  wire [9:0] vref_in,
   input  wire [9:0] step_in,
   // sense comparator
   output wire       cmp_above_out
);
   int cur_reg = 0; // coil current in reference code units
   // ramps while the switch conducts, decays through the freewheel diode
   always @(posedge core_clk_in)
      if (gate_in)
         cur_reg <= cur_reg + int'(step_in);
      else
         cur_reg <= cur_reg - cur_reg / 8 - (cur_reg > 0 ? 1 : 0);
   // sensed current above the active reference
   assign cmp_above_out = cur_reg > int'(vref_in);
endmodule // phd_coil_model

// ===== test/phd_ctrl_chk.sv
// assertion checker for the peak-and-hold solenoid controller ports
`timescale 1ns/1ns
module phd_ctrl_chk #(
   parameter int TRIP_MIN = 188 // minimum on cycles for the period in use
)(
   // clock and reset
   input wire core_clk_in,
   input wire rst_n_in,
   // inputs seen
   input wire enable_in,
   input wire cmp_above_in,
   input wire uvlo_in,
   input wire tsd_in,
   // outputs seen
   input wire gate_out,
   input wire hold_sel_out,
   input wire status_out,
   input wire status_oe_n_out
);
   reg  [11:0] on_len_reg;  // cycles the gate has stood high, saturating
   wire [11:0] on_len_next; // next on length
   assign on_len_next = !gate_out ? 12'h000 : on_len_reg + {11'h000, ~&on_len_reg};
   // count the gate on time
   always @(posedge core_clk_in or negedge rst_n_in)
      if (!rst_n_in)
         on_len_reg <= 12'h000;
      else
         on_len_reg <= on_len_next;
   default clocking dcb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   // an on cycle begins
   sequence s_on_start;
      $rose(gate_out);
   endsequence
   // gate dropped before the minimum on time
   sequence s_early_off;
      s_on_start ##[1:7] $fell(gate_out);
   endsequence
   a_gate_en_off: assert property (!enable_in |=> !gate_out)
      else $error("gate on after enable low");
   a_hold_abort: assert property (!enable_in |=> !hold_sel_out)
      else $error("hold phase kept after enable low");
   a_peak_first: assert property ($rose(enable_in) |=> !hold_sel_out [*8])
      else $error("hold phase without a peak phase");
   a_min_on_time: assert property (s_early_off |-> $past(!enable_in || uvlo_in || tsd_in))
      else $error("gate pulse shorter than minimum on time");
   a_trip_gate_off: assert property (gate_out && cmp_above_in &&
      (int'(on_len_reg) + 1 >= TRIP_MIN) |=> !gate_out)
      else $error("gate stayed on after comparator trip");
   a_gate_keep_on: assert property (gate_out && !cmp_above_in && enable_in &&
      !uvlo_in && !tsd_in |=> gate_out)
      else $error("gate dropped while current below reference");
   a_rise_needs_en: assert property (s_on_start |-> $past(enable_in))
      else $error("gate on cycle without enable");
   a_fault_level: assert property ($past(rst_n_in) |-> status_out == $past(uvlo_in || tsd_in))
      else $error("fault status does not follow lockout inputs");
   a_drain_match: assert property (status_oe_n_out == status_out)
      else $error("fault pin enable differs from fault level");
endmodule // phd_ctrl_chk

// ===== test/phd_ctrl_tb_top.sv
// self-checking bench for the peak-and-hold solenoid controller
`timescale 1ns/1ns
`include "phd_defines.vh"
module phd_ctrl_tb_top;
   // ------------------------------------------------------------
   // signals and model state
   // ------------------------------------------------------------
   localparam int KEEP_US = 20;                      // shortened dwell
   localparam int DWELL   = KEEP_US * `PHD_US_CYC;   // dwell in cycles
   localparam int PER     = 100;                     // pwm period in cycles
   logic        core_clk_in  = 1'b0;
   logic        rst_n_in     = 1'b0;
   logic [7:0]  reg_addr_in  = 8'h00;
   logic [31:0] reg_wdata_in = 32'h00000000;
   logic        reg_wr_in    = 1'b0;
   logic        reg_rd_in    = 1'b0;
   logic        enable_in    = 1'b0;
   logic        uvlo_in      = 1'b0;
   logic        tsd_in       = 1'b0;
   logic [9:0]  step_reg     = 10'h010;               // coil ramp per cycle
   wire         cmp_above_in, gate_out, hold_sel_out, status_out, status_oe_n_out, irq_out;
   wire  [9:0]  vref_code_out;
   wire  [31:0] reg_rdata_out;
   logic [31:0] rdv;                                  // last read word
   logic [31:0] seed = 32'hac932f7d;                  // xorshift state
   int          err_count = 0;
   int          n_checks = 0;
   int          rise_cnt = 0;                         // gate on cycles seen
   always #10 core_clk_in = ~core_clk_in;
   always @(posedge gate_out) rise_cnt++;
   phd_ctrl #(.KEEP_DEF(KEEP_US)) phd_ctrl_inst (.core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .enable_in(enable_in), .cmp_above_in(cmp_above_in), .uvlo_in(uvlo_in),
      .tsd_in(tsd_in), .gate_out(gate_out), .vref_code_out(vref_code_out),
      .hold_sel_out(hold_sel_out), .status_out(status_out),
      .status_oe_n_out(status_oe_n_out), .irq_out(irq_out));
   phd_coil_model phd_coil_model_inst (.core_clk_in(core_clk_in), .gate_in(gate_out),
      .vref_in(vref_code_out), .step_in(step_reg), .cmp_above_out(cmp_above_in));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // expected reference: clamp, peak, or one sixth for hold
   function automatic logic [9:0] ref_of(input logic [9:0] s, input bit hold);
      if (s < `PHD_SET_MIN)
         return `PHD_REF_DEFAULT;
      return hold ? s / `PHD_HOLD_DIV : s;
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      reg_addr_in  <= a;
      reg_wdata_in <= d;
      reg_wr_in    <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_rd_in   <= 1'b1;
      @(posedge core_clk_in);
      reg_rd_in   <= 1'b0;
      #1 rdv = reg_rdata_out;
   endtask
   task automatic en(input logic v);
      @(posedge core_clk_in);
      enable_in <= v;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   // one activation: optional aborted start, peak, dwell, hold, minimum on pulse
   task automatic activate(input logic [9:0] p, input logic [9:0] h, input bit abort);
      int n;
      int r;
      wr(`PHD_OFS_PEAK_SET, {22'h0, p});
      wr(`PHD_OFS_HOLD_SET, {22'h0, h});
      step_reg <= 10'h008 + 10'(xs() % 32);
      if (abort)
      begin
         en(1'b1);
         cyc(300);
         en(1'b0);
      end
      en(1'b1);
      r = rise_cnt;
      cyc(2);
      chk("peak reference", ref_of(p, 1'b0), vref_code_out);
      n = 2;
      while (hold_sel_out !== 1'b1 && n < 3000)
      begin
         cyc(1);
         n++;
      end
      chk("dwell length", 1, n >= DWELL - 50 && n <= DWELL + 5);
      chk("pulses in dwell", 1, rise_cnt - r >= DWELL / PER - 1 && rise_cnt - r <= DWELL / PER + 1);
      chk("hold reference", ref_of(h, 1'b1), vref_code_out);
      step_reg <= 10'h3ff;
      n = 0;
      while (gate_out !== 1'b0 && n < 300) begin cyc(1); n++; end
      while (gate_out !== 1'b1 && n < 600) begin cyc(1); n++; end
      n = 0;
      while (gate_out === 1'b1 && n < 300) begin cyc(1); n++; end
      chk("minimum on time", (PER * `PHD_DMIN_NUM + `PHD_DMIN_DEN - 1) / `PHD_DMIN_DEN, n);
      cyc(200);
      chk("hold kept", 1, hold_sel_out);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      cyc(1);
      chk("gate at reset", 0, gate_out);
      chk("ref at reset", `PHD_REF_DEFAULT, vref_code_out);
      chk("hold at reset", 0, hold_sel_out);
      rd(`PHD_OFS_KEEP);
      chk("keep reset", KEEP_US, rdv);
      rd(`PHD_OFS_PERIOD);
      chk("period reset", `PHD_PERIOD_RST, rdv);
      wr(`PHD_OFS_STATUS, 32'hffffffff);
      rd(`PHD_OFS_STATUS);
      chk("status idle", 0, rdv);
      rd(8'h1c);
      chk("unmapped read", 0, rdv);
      wr(`PHD_OFS_PERIOD, PER);
      activate(10'h063, 10'h063, 1'b0);
      chk("irq masked", 0, irq_out);
      rd(`PHD_OFS_IRQ_STAT);
      chk("events", 32'h13, rdv & 32'h1f);
      wr(`PHD_OFS_IRQ_MASK, 32'h02);
      cyc(2);
      chk("irq raised", 1, irq_out);
      wr(`PHD_OFS_IRQ_STAT, 32'h03);
      cyc(2);
      chk("irq cleared", 0, irq_out);
      wr(`PHD_OFS_IRQ_MASK, 32'h0c);
      en(1'b0);
      cyc(3);
      chk("abort irq", 1, irq_out);
      rd(`PHD_OFS_STATUS);
      chk("idle phase", 0, rdv & 32'h7);
      wr(`PHD_OFS_IRQ_STAT, 32'h1f);
      activate(10'h064 + 10'(xs() % 924), 10'h064, 1'b1);
      en(1'b0);
      activate(10'h064 + 10'(xs() % 924), 10'h064 + 10'(xs() % 924), 1'b0);
      for (int i = 0; i < 2; i++)
      begin
         wr(`PHD_OFS_IRQ_STAT, 32'h1f);
         if (i == 0) uvlo_in <= 1'b1; else tsd_in <= 1'b1;
         cyc(4);
         chk("fault level", 1, status_out);
         chk("gate in fault", 0, gate_out);
         chk("fault irq", 1, irq_out);
         uvlo_in <= 1'b0;
         tsd_in  <= 1'b0;
         cyc(3);
         chk("fault clear", 0, status_out);
      end
      en(1'b0);
      close_out();
   end
   // hang guard
   initial
   begin
      cyc(100000);
      err_count++;
      close_out();
   end
endmodule // phd_ctrl_tb_top
bind phd_ctrl phd_ctrl_chk #(.TRIP_MIN(8)) phd_ctrl_chk_inst (.core_clk_in(core_clk_in),
   .rst_n_in(rst_n_in), .enable_in(enable_in), .cmp_above_in(cmp_above_in),
   .uvlo_in(uvlo_in), .tsd_in(tsd_in), .gate_out(gate_out), .hold_sel_out(hold_sel_out),
   .status_out(status_out), .status_oe_n_out(status_oe_n_out));
